/* File: rtl/cjs_cascade_sync.sv */
/*
 cascade stream alignment on the JK delimiter, open-drain ready line,
 sync-error detection and the 64 x 8 control register bank.
 assumes the receive stream arrives one symbol pair per local byte clock
 enable, already decoded, and that the wired-AND of ready lines is resolved outside.
*/
`timescale 1ns/100ps
// What this block does
// - release open-drain ready on received JK
// - cascade start high only when all released
// - host gets data only after cascade start
// - at most two consecutive JKs to host per alignment attempt, the count restarts in idle
// - flag error if start late by two edges
// - corrupted JK may leave error undetected
// - sixty-four eight-bit registers on control bus
module cjs_cascade_sync #(
	parameter int NUM_REGS = cjs_pkg::REG_COUNT
) (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic BYTE_CLK_FALL,
	input wire cjs_pkg::cjs_pair_t RX_PAIR,
	input wire logic RX_VALID,
	input wire cjs_pkg::cjs_bus_req_t BUS_REQ,
	output logic [7:0] BUS_RDATA,
	input wire logic CASCADE_START_IN,
	output logic CASCADE_READY_OUT,
	output logic CASCADE_READY_OE,
	output cjs_pkg::cjs_pair_t HOST_PAIR,
	output logic HOST_VALID,
	output logic INT_REQ_N
);
	import cjs_pkg::*;

	// refuse settings the bank and the 2-bit counters cannot serve
	if (NUM_REGS != REG_COUNT) begin : g_bank_size
		$error("register bank must hold 64 registers");
	end
	if (SYNC_EDGES < 1 || SYNC_EDGES > 3) begin : g_sync_edges
		$error("sync edge count must fit the 2-bit counter");
	end
	if (JK_MAX_REPEAT < 1 || JK_MAX_REPEAT > 3) begin : g_jk_repeat
		$error("jk repeat limit must fit the 2-bit counter");
	end
	if (CSE_BIT >= DATA_W) begin : g_cse_bit
		$error("error flag bit lies outside the register");
	end

	typedef enum logic [1:0] {CJS_IDLE, CJS_WAIT, CJS_RUN} cjs_state_t;

	cjs_state_t state, next_state;
	logic [7:0] regs [NUM_REGS];
	logic [7:0] next_regs [NUM_REGS];
	logic start_s1, start_s2;
	logic next_start_s1, next_start_s2;
	logic [1:0] edge_cnt, next_edge_cnt;
	logic [1:0] jk_cnt, next_jk_cnt;
	logic ready_released, next_ready_released;
	cjs_pair_t next_host_pair;
	logic next_host_valid;
	logic [7:0] next_rdata;
	logic sync_err;
	logic cascade_en;
	logic irq_pending;

	assign cascade_en = regs[CASCADE_CTRL_ADDR][CASCADE_EN_BIT];

	// start line comes from the wired-AND outside, synchronise first
	always_comb begin
		next_start_s1 = CASCADE_START_IN;
		next_start_s2 = start_s1;
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			start_s1 <= 1'b0;
			start_s2 <= 1'b0;
		end else begin
			start_s1 <= next_start_s1;
			start_s2 <= next_start_s2;
		end
	end

	// alignment: hunt for JK, wait for the peers, then run
	always_comb begin
		next_state = state;
		next_edge_cnt = edge_cnt;
		next_jk_cnt = jk_cnt;
		next_ready_released = ready_released;
		next_host_pair = HOST_PAIR;
		next_host_valid = 1'b0;
		sync_err = 1'b0;
		case (state)
			CJS_IDLE: begin
				next_ready_released = 1'b0;
				next_edge_cnt = 2'h0;
				next_jk_cnt = 2'h0;
				// a corrupted JK never arms the timer, so no error is flagged
				if (cascade_en && RX_VALID && RX_PAIR.jk) begin
					next_state = CJS_WAIT;
					next_ready_released = 1'b1;
					next_host_pair = RX_PAIR;
					next_host_valid = 1'b1;
					next_jk_cnt = 2'h1;
				end
			end
			CJS_WAIT: begin
				if (start_s2) begin
					next_state = CJS_RUN;
					next_edge_cnt = 2'h0;
				end else if (BYTE_CLK_FALL) begin
					// peers missed the skew window: flag and hunt again
					next_edge_cnt = edge_cnt + 2'h1;
					if (edge_cnt == 2'(SYNC_EDGES - 1)) begin
						sync_err = 1'b1;
						next_state = CJS_IDLE;
					end
				end
				// one more JK while the peers catch up
				if (RX_VALID && RX_PAIR.jk && jk_cnt < 2'(JK_MAX_REPEAT)) begin
					next_host_pair = RX_PAIR;
					next_host_valid = 1'b1;
					next_jk_cnt = jk_cnt + 2'h1;
				end
			end
			CJS_RUN: begin
				// a run of JKs reaches the host only up to the limit
				if (RX_VALID && !(RX_PAIR.jk && jk_cnt >= 2'(JK_MAX_REPEAT))) begin
					next_host_pair = RX_PAIR;
					next_host_valid = 1'b1;
					next_jk_cnt = RX_PAIR.jk ? jk_cnt + 2'h1 : 2'h0;
				end
				// peers dropped ready or mode left: back to hunting
				if (!start_s2 || !cascade_en) begin
					next_state = CJS_IDLE;
				end
			end
			default: begin
				next_state = CJS_IDLE;
			end
		endcase
		if (!cascade_en) begin
			next_state = CJS_IDLE;
			next_ready_released = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= CJS_IDLE;
			edge_cnt <= 2'h0;
			jk_cnt <= 2'h0;
			ready_released <= 1'b0;
			HOST_PAIR <= '0;
			HOST_VALID <= 1'b0;
		end else begin
			state <= next_state;
			edge_cnt <= next_edge_cnt;
			jk_cnt <= next_jk_cnt;
			ready_released <= next_ready_released;
			HOST_PAIR <= next_host_pair;
			HOST_VALID <= next_host_valid;
		end
	end

	// open drain: pull low while not ready, release otherwise
	assign CASCADE_READY_OUT = 1'b0;
	assign CASCADE_READY_OE = !ready_released;

	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			next_regs[i] = regs[i];
		end
		// bus write first, then the hardware set, so the set wins
		if (BUS_REQ.wr) begin
			if (BUS_REQ.addr == RECEIVE_CONDITION_B_ADDR) begin
				// conditional write: a zero clears a flag, a one leaves it
				next_regs[RECEIVE_CONDITION_B_ADDR] = regs[RECEIVE_CONDITION_B_ADDR]
					& BUS_REQ.wdata;
			end else if (BUS_REQ.addr == RECEIVE_CONDITION_MASK_B_ADDR) begin
				next_regs[RECEIVE_CONDITION_MASK_B_ADDR] = BUS_REQ.wdata;
			end else begin
				// reserved locations included: plain storage
				next_regs[BUS_REQ.addr] = BUS_REQ.wdata;
			end
		end
		if (sync_err) begin
			next_regs[RECEIVE_CONDITION_B_ADDR][CSE_BIT] = 1'b1;
		end
		next_rdata = BUS_RDATA;
		if (BUS_REQ.rd) begin
			next_rdata = regs[BUS_REQ.addr];
		end
	end

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= REG_RESET;
			end
			BUS_RDATA <= REG_RESET;
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= next_regs[i];
			end
			BUS_RDATA <= next_rdata;
		end
	end

	// any unmasked receive condition requests service
	assign irq_pending = |(regs[RECEIVE_CONDITION_B_ADDR] & regs[RECEIVE_CONDITION_MASK_B_ADDR]);
	assign INT_REQ_N = !irq_pending;
endmodule

/* File: rtl/cjs_pkg.sv */
/*
 cascade sync package: register map, field positions, reset values, carrier types.
 assumes an 8-bit control bus with 6-bit register addresses.
*/
package cjs_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int REG_COUNT = 64;
	localparam logic [5:0] RECEIVE_CONDITION_B_ADDR = 6'h0A;
	localparam logic [5:0] RECEIVE_CONDITION_MASK_B_ADDR = 6'h0C;
	localparam logic [5:0] CASCADE_CTRL_ADDR = 6'h17;
	localparam int CSE_BIT = 4;
	localparam int CASCADE_EN_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] MASK_B_RESET = 8'h00;
	localparam int SYNC_EDGES = 2;
	localparam int JK_MAX_REPEAT = 2;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cjs_bus_req_t;
	typedef struct packed {
		logic [7:0] symbol_pair;
		logic jk;
	} cjs_pair_t;
endpackage

/* File: test/cjs_cascade_sync_assertions.sv */
/* port checks of the cascade sync block
 assumes one clock and the bind below */
`timescale 1ns/100ps
module cjs_checker (
	input wire logic CLOCK,
	input wire logic ARST_N,
	input wire logic BYTE_CLK_FALL,
	input wire cjs_pkg::cjs_pair_t RX_PAIR,
	input wire logic RX_VALID,
	input wire cjs_pkg::cjs_bus_req_t BUS_REQ,
	input wire logic [7:0] BUS_RDATA,
	input wire logic CASCADE_START_IN,
	input wire logic CASCADE_READY_OUT,
	input wire logic CASCADE_READY_OE,
	input wire cjs_pkg::cjs_pair_t HOST_PAIR,
	input wire logic HOST_VALID,
	input wire logic INT_REQ_N
);
	import cjs_pkg::*;
	logic [2:0] jk_n;
	logic [2:0] next_jk_n;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	// run of JK pairs handed to the host
	always_comb begin
		next_jk_n = jk_n;
		if (HOST_VALID) next_jk_n = HOST_PAIR.jk ? jk_n + 3'h1 : 3'h0;
	end
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) jk_n <= 3'h0;
		else jk_n <= next_jk_n;
	end
	ready_low_a: assert property (CASCADE_READY_OUT == 1'b0)
		else $error("ready driven high");
	ready_rel_a: assert property ($fell(CASCADE_READY_OE) |-> $past(RX_VALID && RX_PAIR.jk))
		else $error("release without jk");
	first_jk_a: assert property ($fell(CASCADE_READY_OE) |-> HOST_VALID && HOST_PAIR.jk)
		else $error("jk not passed");
	jk_limit_a: assert property (jk_n <= 3'h2)
		else $error("too many jk");
	host_gate_a: assert property (HOST_VALID && !HOST_PAIR.jk |-> $past(CASCADE_START_IN, 4))
		else $error("data before start");
	err_ret_a: assert property ($rose(CASCADE_READY_OE) |-> $past(BYTE_CLK_FALL, 2)
		|| $past(BUS_REQ.wr, 2) || !$past(CASCADE_START_IN, 4))
		else $error("ready pulled early");
	int_set_a: assert property ($fell(INT_REQ_N) |-> $past(BUS_REQ.wr) || $past(BYTE_CLK_FALL))
		else $error("int without cause");
	int_clr_a: assert property ($rose(INT_REQ_N) |-> $past(BUS_REQ.wr))
		else $error("int not sticky");
	rdata_hold_a: assert property (!$past(BUS_REQ.rd) |-> $stable(BUS_RDATA))
		else $error("rdata moved");
endmodule
bind cjs_cascade_sync cjs_checker chk_u (.*);

/* File: test/cjs_peer_model.sv */
/* peer device on the wired-AND ready line
 assumes go pulses with the shared JK */
`timescale 1ns/100ps
module cjs_peer_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic go,
	input wire logic [7:0] lag,
	input wire logic dut_oe,
	output logic start
);
	logic [7:0] n;
	logic oe;
	assign start = !(dut_oe || oe);
	// own JK arrives lag cycles after the shared one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			n <= 8'h00;
			oe <= 1'b1;
		end else if (go) begin
			n <= lag;
			oe <= 1'b1;
		end else if (n != 8'h00) begin
			n <= n - 8'h01;
			oe <= (n != 8'h01);
		end
	end
endmodule

/* File: test/tb_top.sv */
/* self-checking bench of cjs_cascade_sync
 assumes the peer model closes the ready line */
`timescale 1ns/100ps
module tb_top;
	import cjs_pkg::*;
	logic CLOCK = 0, ARST_N = 0, BYTE_CLK_FALL = 0, RX_VALID = 0, go = 0;
	logic [7:0] lag = 8'h01;
	logic [7:0] BUS_RDATA;
	cjs_pair_t RX_PAIR = '0;
	cjs_pair_t HOST_PAIR;
	cjs_bus_req_t BUS_REQ = '0;
	logic CASCADE_START_IN, CASCADE_READY_OUT, CASCADE_READY_OE, HOST_VALID, INT_REQ_N;
	int num_errors = 0, samples_checked = 0, cyc = 0;
	always #50 CLOCK = !CLOCK;
	always @(posedge CLOCK) begin
		cyc++;
		#10 BYTE_CLK_FALL = (cyc % 8 == 0);
	end
	cjs_cascade_sync dut_u (.*);
	cjs_peer_model peer_u (.clk(CLOCK), .arst_n(ARST_N), .go(go), .lag(lag),
		.dut_oe(CASCADE_READY_OE), .start(CASCADE_START_IN));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic [5:0] a, input logic [7:0] d, input logic w);
		@(posedge CLOCK) #10 BUS_REQ = '{a, d, w, !w};
		@(posedge CLOCK) #10 BUS_REQ = '0;
	endtask
	task send(input logic j, input logic [7:0] d);
		@(posedge CLOCK) #10 RX_PAIR = '{d, j};
		RX_VALID = 1;
		go = j && CASCADE_READY_OE;
		@(posedge CLOCK) #10 RX_VALID = 0;
		go = 0;
	endtask
	task t_regs;
		chk({7'h0, CASCADE_READY_OE}, 8'h01);
		bus(6'h0A, 8'h00, 0);
		chk(BUS_RDATA, REG_RESET);
		bus(6'h0C, 8'h10, 1);
		bus(6'h0C, 8'h00, 0);
		chk(BUS_RDATA, 8'h10);
	endtask
	task t_sync;
		bus(6'h17, 8'h01, 1);
		send(1, 8'h11);
		chk({5'h0, CASCADE_READY_OE, HOST_VALID, HOST_PAIR.jk}, 8'h03);
		send(1, 8'h11);
		chk({7'h0, HOST_VALID}, 8'h01);
		repeat (4) @(posedge CLOCK);
		send(0, 8'h5A);
		chk({HOST_PAIR.symbol_pair[6:0], HOST_VALID}, 8'hB5);
		chk({6'h0, CASCADE_START_IN, CASCADE_READY_OE}, 8'h02);
	endtask
	task t_late;
		repeat (8) @(posedge CLOCK);
		bus(6'h17, 8'h00, 1);
		lag = 8'd60;
		bus(6'h17, 8'h01, 1);
		send(1, 8'h11);
		send(0, 8'h5A);
		chk({7'h0, HOST_VALID}, 8'h00);
		repeat (20) @(posedge CLOCK);
		#10;
		chk({6'h0, CASCADE_READY_OE, INT_REQ_N}, 8'h02);
		bus(6'h0A, 8'h00, 0);
		chk(BUS_RDATA, 8'h10);
		bus(6'h0A, 8'hEF, 1);
		bus(6'h0A, 8'h00, 0);
		chk({BUS_RDATA[6:0], INT_REQ_N}, 8'h01);
		bus(6'h3F, 8'h00, 0);
	endtask
	task complete_run;
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge CLOCK);
		#10 ARST_N = 1;
		t_regs;
		t_sync;
		t_late;
		complete_run;
	end
	initial begin
		#100000 num_errors++;
		complete_run;
	end
endmodule
